/* pkg/dsg_pkg.sv */
// shared constants for the deep-sleep clock gating block
package dsg_pkg;

   ////////////////////////////////////////////////////////////////////////
   // units handled by the gating register, in unit-vector order
   localparam int DSG_UNITS = 5;
   localparam int DSG_U_WDT = 0;
   localparam int DSG_U_HIB = 1;
   localparam int DSG_U_ADC = 2;
   localparam int DSG_U_BUS0 = 3;
   localparam int DSG_U_BUS1 = 4;

   // bit position of each unit enable inside the gating register
   localparam int DSG_BIT_WDT = 3;
   localparam int DSG_BIT_HIB = 6;
   localparam int DSG_BIT_ADC = 16;
   localparam int DSG_BIT_BUS0 = 24;
   localparam int DSG_BIT_BUS1 = 25;
   localparam int DSG_UNIT_BIT [DSG_UNITS] = '{DSG_BIT_WDT, DSG_BIT_HIB,
      DSG_BIT_ADC, DSG_BIT_BUS0, DSG_BIT_BUS1};

   ////////////////////////////////////////////////////////////////////////
   // register map, byte addresses
   localparam int DSG_ADDR_W = 12;
   localparam logic [11:0] DSG_OFS_DEEP_GATE = 12'h120;
   localparam logic [11:0] DSG_OFS_INT_STATUS = 12'h124;
   localparam logic [11:0] DSG_OFS_INT_MASK = 12'h128;
   localparam logic [11:0] DSG_OFS_APPLIED = 12'h12c;

   // reset values and writable bits
   localparam logic [31:0] DSG_DEEP_GATE_RESET = 32'h0000_0040;
   localparam logic [31:0] DSG_DEEP_GATE_WMASK = 32'h0301_0048;
   localparam logic [1:0] DSG_INT_STATUS_RESET = 2'h0;
   localparam logic [1:0] DSG_INT_MASK_RESET = 2'h0;

   // interrupt status / mask layout
   localparam int DSG_EVT_W = 2;
   localparam int DSG_EVT_FAULT = 0;
   localparam int DSG_EVT_DEEP = 1;

   // applied-state register layout
   localparam int DSG_APP_SRC_LSB = 8;
   localparam int DSG_APP_ACG_BIT = 12;

   ////////////////////////////////////////////////////////////////////////
   // power mode codes on the mode input, and the applied source
   localparam logic [1:0] DSG_MODE_RUN = 2'h0;
   localparam logic [1:0] DSG_MODE_SLEEP = 2'h1;
   localparam logic [1:0] DSG_MODE_DEEP = 2'h2;

   // avalon response codes
   localparam logic [1:0] DSG_RESP_OK = 2'h0;
   localparam logic [1:0] DSG_RESP_DECODE = 2'h3;

   typedef enum logic {
      DSG_BUS_IDLE,
      DSG_BUS_ACK
   } dsg_bus_state_t;

endpackage

/* src/dsg_fault_chk.sv */
// flags accesses to units whose clock is off
`timescale 1ns/1ps
`default_nettype none

module dsg_fault_chk
   import dsg_pkg::*;
#(
   parameter int UNITS = DSG_UNITS
) (
   input wire logic [UNITS-1:0] clk_en_i,
   input wire logic [UNITS-1:0] access_i,
   output logic [UNITS-1:0] fault_o
);

   genvar g;
   generate
      for (g = 0; g < UNITS; g++) begin : g_unit
         // gated unit answers with a fault
         assign fault_o[g] = access_i[g] & ~clk_en_i[g];
      end
   endgenerate

endmodule

`default_nettype wire

/* src/dsg_gate_sel.sv */
// picks which gating set drives the unit clocks
`timescale 1ns/1ps
`default_nettype none

module dsg_gate_sel
   import dsg_pkg::*;
#(
   parameter int UNITS = DSG_UNITS
) (
   input wire logic [UNITS-1:0] run_gate_i,
   input wire logic [UNITS-1:0] sleep_gate_i,
   input wire logic [UNITS-1:0] deep_gate_i,
   input wire logic auto_gating_select_i,
   input wire logic [1:0] power_mode_i,
   output logic [UNITS-1:0] gate_o,
   output logic [1:0] source_o
);

   wire use_sleep;
   wire use_deep;

   // sleep sets only count with automatic gating selected
   assign use_sleep = auto_gating_select_i &&
      (power_mode_i == DSG_MODE_SLEEP);
   // deep set only in deep sleep
   assign use_deep = auto_gating_select_i &&
      (power_mode_i == DSG_MODE_DEEP);

   // otherwise the run set stays in force
   assign gate_o = use_deep ? deep_gate_i :
      (use_sleep ? sleep_gate_i : run_gate_i);
   assign source_o = use_deep ? DSG_MODE_DEEP :
      (use_sleep ? DSG_MODE_SLEEP : DSG_MODE_RUN);

endmodule

`default_nettype wire

/* src/dsg_top.sv */
// deep-sleep clock gating register with avalon slave and interrupt
//
// What this block does
// - each implemented gating bit is the clock enable of one unit.
// - a read or write to a unit whose clock is off is answered by a fault.
// - gating bits reset to zero except those given another reset value.
// - this register's enables apply only while the system is in deep sleep.
// - sleep and deep-sleep sets apply only with automatic gating selected.
// - bits 25, 24 and 16 gate bus unit one, bus unit zero and the converter.
// - bit 6 gates the hibernation module and resets to one.
// - bit 3 gates the watchdog, resets to zero, and gated access faults.
// - reserved bits read as zero and ignore writes.
`timescale 1ns/1ps
`default_nettype none

module dsg_top
   import dsg_pkg::*;
#(
   parameter int UNITS = DSG_UNITS,
   parameter int ADDR_W = DSG_ADDR_W
) (
   input wire logic mclk_i,
   input wire logic reset_i,
   // avalon-mm slave
   input wire logic [ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   output logic [1:0] avs_response_o,
   // system state, from logic on the same clock
   input wire logic [1:0] power_mode_i,
   input wire logic auto_gating_select_i,
   input wire logic [UNITS-1:0] run_gate_i,
   input wire logic [UNITS-1:0] sleep_gate_i,
   // fabric access strobes, one per unit
   input wire logic [UNITS-1:0] unit_access_i,
   // unit clock enables and per-unit fault answers
   output logic [UNITS-1:0] unit_clk_en_o,
   output logic [UNITS-1:0] unit_fault_o,
   output logic irq_o
);

   ////////////////////////////////////////////////////////////////////////
   // storage
   logic [31:0] deep_sleep_gate_reg;
   logic [31:0] deep_sleep_gate_next;
   logic [DSG_EVT_W-1:0] int_status_reg;
   logic [DSG_EVT_W-1:0] int_status_next;
   logic [DSG_EVT_W-1:0] int_mask_reg;
   logic [DSG_EVT_W-1:0] int_mask_next;
   logic [UNITS-1:0] clk_en_reg;
   logic [UNITS-1:0] fault_reg;
   logic [1:0] source_reg;
   logic irq_reg;
   dsg_bus_state_t bus_state_reg;
   dsg_bus_state_t bus_state_next;
   logic [31:0] rdata_reg;
   logic [1:0] resp_reg;
   logic wait_reg;

   ////////////////////////////////////////////////////////////////////////
   // bus decode
   wire bus_req;
   wire bus_commit;
   wire sel_gate;
   wire sel_status;
   wire sel_mask;
   wire sel_applied;
   wire sel_any;
   wire [31:0] byte_mask;
   wire [31:0] gate_wmask;
   wire [31:0] rd_mux;

   assign bus_req = avs_read_i | avs_write_i;
   // a write takes effect at the edge where waitrequest is seen low
   assign bus_commit = avs_write_i && (bus_state_reg == DSG_BUS_ACK);
   assign sel_gate = (avs_address_i == DSG_OFS_DEEP_GATE);
   assign sel_status = (avs_address_i == DSG_OFS_INT_STATUS);
   assign sel_mask = (avs_address_i == DSG_OFS_INT_MASK);
   assign sel_applied = (avs_address_i == DSG_OFS_APPLIED);
   assign sel_any = sel_gate | sel_status | sel_mask | sel_applied;
   assign byte_mask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
      {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
   // only unit bits are writable, the rest stay zero
   assign gate_wmask = byte_mask & DSG_DEEP_GATE_WMASK;

   ////////////////////////////////////////////////////////////////////////
   // gating selection and fault check
   wire [UNITS-1:0] deep_units;
   wire [UNITS-1:0] gate_sel;
   wire [1:0] source_sel;
   wire [UNITS-1:0] fault_now;

   genvar g;
   generate
      for (g = 0; g < UNITS; g++) begin : g_unit
         // one enable bit per unit at its fixed position
         assign deep_units[g] = deep_sleep_gate_reg[DSG_UNIT_BIT[g]];
      end
   endgenerate

   dsg_gate_sel #(
      .UNITS(UNITS)
   ) u_sel (
      .run_gate_i(run_gate_i),
      .sleep_gate_i(sleep_gate_i),
      .deep_gate_i(deep_units),
      .auto_gating_select_i(auto_gating_select_i),
      .power_mode_i(power_mode_i),
      .gate_o(gate_sel),
      .source_o(source_sel)
   );

   // checked against the enables in force, the watchdog included
   dsg_fault_chk #(
      .UNITS(UNITS)
   ) u_fault (
      .clk_en_i(clk_en_reg),
      .access_i(unit_access_i),
      .fault_o(fault_now)
   );

   ////////////////////////////////////////////////////////////////////////
   // interrupt events
   wire evt_fault;
   wire evt_deep;
   wire [DSG_EVT_W-1:0] evt_vec;
   wire [DSG_EVT_W-1:0] w1c;

   assign evt_fault = |fault_now;
   assign evt_deep = (source_sel == DSG_MODE_DEEP) &&
      (source_reg != DSG_MODE_DEEP);
   assign evt_vec = {evt_deep, evt_fault};
   assign w1c = (bus_commit && sel_status && avs_byteenable_i[0]) ?
      avs_writedata_i[DSG_EVT_W-1:0] : '0;

   ////////////////////////////////////////////////////////////////////////
   // next-state logic
   // only unit bits reach the register, reserved bits hold zero
   assign deep_sleep_gate_next = (bus_commit && sel_gate) ?
      ((deep_sleep_gate_reg & ~gate_wmask) |
       (avs_writedata_i & gate_wmask)) :
      deep_sleep_gate_reg;
   // set wins over a clear in the same cycle
   assign int_status_next = (int_status_reg & ~w1c) | evt_vec;
   assign int_mask_next = (bus_commit && sel_mask && avs_byteenable_i[0]) ?
      avs_writedata_i[DSG_EVT_W-1:0] : int_mask_reg;
   assign bus_state_next = (bus_state_reg == DSG_BUS_IDLE && bus_req) ?
      DSG_BUS_ACK : DSG_BUS_IDLE;

   // read mux, unmapped addresses read zero
   wire [31:0] rd_status;
   wire [31:0] rd_mask;
   wire [31:0] rd_applied;

   assign rd_status = {{(32-DSG_EVT_W){1'b0}}, int_status_reg};
   assign rd_mask = {{(32-DSG_EVT_W){1'b0}}, int_mask_reg};
   assign rd_applied = {{(32-UNITS){1'b0}}, clk_en_reg} |
      ({30'h0000_0000, source_reg} << DSG_APP_SRC_LSB) |
      ({31'h0000_0000, auto_gating_select_i} << DSG_APP_ACG_BIT);
   assign rd_mux = sel_gate ? deep_sleep_gate_reg :
      (sel_status ? rd_status :
      (sel_mask ? rd_mask :
      (sel_applied ? rd_applied : 32'h0000_0000)));

   ////////////////////////////////////////////////////////////////////////
   // registers
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         // hibernation bit comes up set, all others clear
         deep_sleep_gate_reg <= DSG_DEEP_GATE_RESET;
         int_status_reg <= DSG_INT_STATUS_RESET;
         int_mask_reg <= DSG_INT_MASK_RESET;
      end else begin
         deep_sleep_gate_reg <= deep_sleep_gate_next;
         int_status_reg <= int_status_next;
         int_mask_reg <= int_mask_next;
      end
   end

   // applied enables drive the unit clocks
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         clk_en_reg <= '0;
         source_reg <= DSG_MODE_RUN;
         fault_reg <= '0;
         irq_reg <= 1'b0;
      end else begin
         clk_en_reg <= gate_sel;
         source_reg <= source_sel;
         fault_reg <= fault_now;
         irq_reg <= |(int_status_next & int_mask_next);
      end
   end

   // one wait cycle, then the answer; readdata sampled at the first edge of the request
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         bus_state_reg <= DSG_BUS_IDLE;
         rdata_reg <= 32'h0000_0000;
         resp_reg <= DSG_RESP_OK;
         wait_reg <= 1'b1;
      end else begin
         bus_state_reg <= bus_state_next;
         // own flop so waitrequest carries no decode glitch
         wait_reg <= (bus_state_next != DSG_BUS_ACK);
         if (bus_state_reg == DSG_BUS_IDLE && bus_req) begin
            rdata_reg <= avs_read_i ? rd_mux : 32'h0000_0000;
            resp_reg <= sel_any ? DSG_RESP_OK : DSG_RESP_DECODE;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs straight from flops
   assign avs_readdata_o = rdata_reg;
   assign avs_waitrequest_o = wait_reg;
   assign avs_response_o = resp_reg;
   assign unit_clk_en_o = clk_en_reg;
   assign unit_fault_o = fault_reg;
   assign irq_o = irq_reg;

endmodule

`default_nettype wire

/* testbench/dsg_chk.sv */
// assertions on the ports of the deep-sleep gating block
`timescale 1ns/1ps
`default_nettype none
module dsg_chk
   import dsg_pkg::*;
#(
   parameter int UNITS = DSG_UNITS,
   parameter int ADDR_W = DSG_ADDR_W
) (
   input wire logic mclk_i,
   input wire logic reset_i,
   input wire logic [ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_readdata_o,
   input wire logic avs_waitrequest_o,
   input wire logic [1:0] avs_response_o,
   input wire logic [1:0] power_mode_i,
   input wire logic auto_gating_select_i,
   input wire logic [UNITS-1:0] run_gate_i,
   input wire logic [UNITS-1:0] sleep_gate_i,
   input wire logic [UNITS-1:0] unit_access_i,
   input wire logic [UNITS-1:0] unit_clk_en_o,
   input wire logic [UNITS-1:0] unit_fault_o
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (reset_i);
   wire logic req = (avs_read_i | avs_write_i) & avs_waitrequest_o;
   wire logic mapped = avs_address_i inside {DSG_OFS_DEEP_GATE,
      DSG_OFS_INT_STATUS, DSG_OFS_INT_MASK, DSG_OFS_APPLIED};
   wire logic run_sel = !auto_gating_select_i ||
      power_mode_i == DSG_MODE_RUN || power_mode_i == 2'h3;
   wire logic deep = auto_gating_select_i && power_mode_i == DSG_MODE_DEEP;
   ////////////////////////////////////////////////////////////////////
   sequence s_answer;
      !avs_waitrequest_o ##1 avs_waitrequest_o;
   endsequence
   sequence s_deep_quiet;
      deep && !avs_write_i;
   endsequence
   property p_answer;
      req |=> s_answer;
   endproperty
   property p_idle;
      !avs_read_i && !avs_write_i && avs_waitrequest_o |=> avs_waitrequest_o;
   endproperty
   property p_rsvd;
      req && avs_read_i && avs_address_i == DSG_OFS_DEEP_GATE |=>
         (avs_readdata_o & 32'hfcfe_ffb7) == 32'h0;
   endproperty
   property p_decode;
      req && avs_read_i && !mapped |=>
         avs_response_o == DSG_RESP_DECODE && avs_readdata_o == 32'h0;
   endproperty
   property p_fault;
      1'b1 |=> unit_fault_o == $past(unit_access_i & ~unit_clk_en_o);
   endproperty
   property p_run;
      run_sel |=> unit_clk_en_o == $past(run_gate_i);
   endproperty
   property p_sleep;
      auto_gating_select_i && power_mode_i == DSG_MODE_SLEEP |=>
         unit_clk_en_o == $past(sleep_gate_i);
   endproperty
   property p_deep;
      s_deep_quiet ##1 s_deep_quiet |=> $stable(unit_clk_en_o);
   endproperty
   a_answer: assert property (p_answer) else $error("no one-cycle answer");
   a_idle: assert property (p_idle) else $error("answer without request");
   a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
   a_decode: assert property (p_decode) else $error("bad unmapped answer");
   a_fault: assert property (p_fault) else $error("fault wrong");
   a_run: assert property (p_run) else $error("run set not applied");
   a_sleep: assert property (p_sleep) else $error("sleep set wrong");
   a_deep: assert property (p_deep) else $error("deep enables moved");
endmodule
bind dsg_top dsg_chk #(.UNITS(UNITS), .ADDR_W(ADDR_W)) dsg_chk_inst (
   .mclk_i, .reset_i, .avs_address_i, .avs_read_i, .avs_write_i,
   .avs_readdata_o, .avs_waitrequest_o, .avs_response_o, .power_mode_i,
   .auto_gating_select_i, .run_gate_i, .sleep_gate_i, .unit_access_i,
   .unit_clk_en_o, .unit_fault_o);
`default_nettype wire

/* testbench/dsg_fabric_model.sv */
// bus fabric and gated units: access strobes and fault capture
`timescale 1ns/1ps
`default_nettype none
module dsg_fabric_model (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic [4:0] req_i,
   input wire logic [4:0] fault_i,
   output logic [4:0] access_o,
   output logic [4:0] fault_seen_o
);
   // sticky so a one-cycle fault pulse is never missed by the bench
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         access_o <= 5'h00;
         fault_seen_o <= 5'h00;
      end else begin
         access_o <= req_i;
         fault_seen_o <= fault_seen_o | fault_i;
      end
   end
endmodule
`default_nettype wire

/* testbench/dsg_top_tb.sv */
// self-checking bench for the deep-sleep gating block
`timescale 1ns/1ps
`default_nettype none
module dsg_top_tb import dsg_pkg::*;;
   logic clk = 0, rst = 1, rd = 0, wr = 0, auto_gating_select = 0, wq, irq;
   logic [11:0] adr = 12'h000;
   logic [31:0] wd = 32'h0, rdo, rdata;
   logic [3:0] be = 4'hf;
   logic [1:0] resp, rsp, mode = 2'h0;
   logic [4:0] rg = 5'h00, sg = 5'h00, req = 5'h00, acc, en, flt, fseen;
   int n_mismatch = 0, n_checks = 0, n_cyc = 0;
   dsg_top dsg_top_inst (.mclk_i(clk), .reset_i(rst), .avs_address_i(adr),
      .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
      .avs_byteenable_i(be), .avs_readdata_o(rdo), .avs_waitrequest_o(wq),
      .avs_response_o(resp), .power_mode_i(mode),
      .auto_gating_select_i(auto_gating_select), .run_gate_i(rg), .sleep_gate_i(sg),
      .unit_access_i(acc), .unit_clk_en_o(en), .unit_fault_o(flt),
      .irq_o(irq));
   dsg_fabric_model dsg_fabric_model_inst (.mclk_i(clk), .rst_i(rst),
      .req_i(req), .fault_i(flt), .access_o(acc), .fault_seen_o(fseen));
   always #50 clk = ~clk;
   always @(posedge clk) begin
      n_cyc++;
      if (n_cyc == 3000) begin
         n_mismatch++;
         test_done();
      end
   end
   ////////////////////////////////////////////////////////////////////
   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // waits on waitrequest alone; the cycle timeout ends a hang
   task automatic bus(input logic w, input logic [11:0] a,
         input logic [31:0] d);
      @(posedge clk);
      adr <= a;
      wd <= d;
      wr <= w;
      rd <= !w;
      do @(posedge clk); while (wq !== 1'b0);
      rdata = rdo;
      rsp = resp;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(rdata, exp);
   endtask
   ////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      rchk(DSG_OFS_DEEP_GATE, 32'h0000_0040);
      rchk(DSG_OFS_INT_STATUS, 32'h0);
      rchk(DSG_OFS_INT_MASK, 32'h0);
      for (int i = 0; i < DSG_UNITS; i++) begin
         bus(1'b1, DSG_OFS_DEEP_GATE, 32'h1 << DSG_UNIT_BIT[i]);
         rchk(DSG_OFS_DEEP_GATE, 32'h1 << DSG_UNIT_BIT[i]);
      end
      bus(1'b1, DSG_OFS_DEEP_GATE, 32'hffff_ffff);
      rchk(DSG_OFS_DEEP_GATE, 32'h0301_0048);
      be <= 4'h1;
      bus(1'b1, DSG_OFS_DEEP_GATE, 32'h0);
      be <= 4'hf;
      rchk(DSG_OFS_DEEP_GATE, 32'h0301_0000);
      bus(1'b0, DSG_OFS_DEEP_GATE, 32'h0);
      bus(1'b1, DSG_OFS_DEEP_GATE, rdata | 32'h40);
      bus(1'b1, 12'h200, 32'hffff_ffff);
      rchk(12'h200, 32'h0);
      chk(rsp, DSG_RESP_DECODE);
      rchk(DSG_OFS_DEEP_GATE, 32'h0301_0040);
      $display("test registers done");
      rg <= 5'h15;
      sg <= 5'h0a;
      mode <= DSG_MODE_DEEP;
      repeat (3) @(posedge clk);
      chk(en, 5'h15);
      auto_gating_select <= 1'b1;
      mode <= DSG_MODE_RUN;
      repeat (3) @(posedge clk);
      chk(en, 5'h15);
      mode <= DSG_MODE_SLEEP;
      repeat (3) @(posedge clk);
      chk(en, 5'h0a);
      mode <= DSG_MODE_DEEP;
      repeat (3) @(posedge clk);
      chk(en, 5'h1e);
      rchk(DSG_OFS_APPLIED, 32'h0000_121e);
      req <= 5'h03;
      @(posedge clk);
      req <= 5'h00;
      repeat (3) @(posedge clk);
      chk(fseen, 5'h01);
      $display("test gating done");
      rchk(DSG_OFS_INT_STATUS, 32'h3);
      chk(irq, 1'b0);
      bus(1'b1, DSG_OFS_INT_MASK, 32'h1);
      repeat (2) @(posedge clk);
      chk(irq, 1'b1);
      bus(1'b1, DSG_OFS_INT_STATUS, 32'h1);
      repeat (2) @(posedge clk);
      chk(irq, 1'b0);
      rchk(DSG_OFS_INT_STATUS, 32'h2);
      $display("test interrupt done");
      test_done();
   end
endmodule
`default_nettype wire
